/* File: iac_client.sv */
// I2C client: address match, software clock stretching, byte count, 8-bit receive.
// Assumes an external host drives SCL/SDA; software controls via plain ports.
// How it works
// - Address hold: stretch after matching address byte
// - Write hold: stretch after each received byte
// - Ack-time hold: stretch after every acknowledge
// - Counter drops per data byte, floors zero
// - Count-zero flag set on ninth falling edge
// - Auto-load takes first data byte as count
// - Receive decrement on eighth falling edge
// - Plain 7-bit: four independent compares, LSb ignored
// - 7-bit masked: slots 0/2 masked by 1/3
// - 10-bit: pairs 0/1 and 2/3 form addresses
// - 10-bit masked: pair 2/3 masks pair 0/1
// - 10-bit compares all fifteen stored bits
// - No match: silent, back to idle
// - General call acked only when enabled, 7-bit
// - Received LSb becomes read-request status
// - Start sets start flag, maybe combined flag
// - Match: active, address stored, match flag
// - Pending error forces NACK on address
// - Full receive buffer stretches until read
// - Eighth pulse loads buffer, sets data flags
// - Ack value from counter state, ninth pulse
// - NACK or stop sets flag, goes idle
// - Overflow without stretching; NACK afterwards
`timescale 1ns/1ps
module iac_client (
	input  wire logic               CLK_IN,
	input  wire logic               RESETN_IN,
	input  wire logic               CE_IN,
	input  wire logic               SCL_IN,
	input  wire logic               SDA_IN,
	output logic                    SCL_OUT,
	output logic                    SCL_OE_OUT,
	output logic                    SDA_OUT,
	output logic                    SDA_OE_OUT,
	input  wire iac_pkg::iac_cfg_s  CFG_IN,
	input  wire logic [3:0][7:0]    MATCH_VALUE_IN,
	input  wire logic               STRETCH_CLR_IN,
	input  wire logic               RX_READ_IN,
	input  wire logic               ERR_CLR_IN,
	input  wire iac_pkg::iac_flags_s FLAG_CLR_IN,
	input  wire logic               CNT_WR_IN,
	input  wire logic [7:0]         CNT_WDATA_IN,
	output iac_pkg::iac_stat_s      STAT_OUT,
	output iac_pkg::iac_flags_s     FLAGS_OUT,
	output logic [7:0]              RX_DATA_OUT,
	output logic [7:0]              ADDR_BUF0_OUT,
	output logic [7:0]              BYTE_COUNTER_OUT
);
	import iac_pkg::*;

	logic       sda_s, rise_p, fall_p, start_p, stop_p;
	iac_state_e st_reg, st_next, ack_to_reg, ack_to_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next, hi_reg, hi_next;
	logic [1:0] hit_reg, hit_next;
	logic       first_reg, first_next, nack_reg, nack_next, final_reg, final_next;
	logic       pend_reg, pend_next, stall_reg, stall_next;
	logic       scl_oe_next, sda_oe_next;
	logic [7:0] cnt_next, rx_next, adb_next;
	iac_stat_s  stat_next;
	iac_flags_s flags_next, fl_set;
	logic [3:0] slot_eq;
	logic       seven, ten, match7, hi_hit0, hi_hit1, match_lo, ack_bit;
	logic       go_ack, hold, autoload;
	logic       ev_addr, ev_data, ev_ack, ev_stall;

	iac_sync u_sync (
		.clk_in    (CLK_IN),
		.resetn_in (RESETN_IN),
		.ce_in     (CE_IN),
		.scl_in    (SCL_IN),
		.sda_in    (SDA_IN),
		.sda_out   (sda_s),
		.rise_out  (rise_p),
		.fall_out  (fall_p),
		.start_out (start_p),
		.stop_out  (stop_p)
	);

	// Open-drain pins only ever pull low
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_slot
			assign slot_eq[gi] = shift_reg[7:1] == MATCH_VALUE_IN[gi][7:1];
		end
	endgenerate

	always_comb begin
		seven = CFG_IN.mode == MODE_7B || CFG_IN.mode == MODE_7B_MASK
			|| CFG_IN.mode == MODE_MH_MASK;
		ten   = CFG_IN.mode == MODE_10B || CFG_IN.mode == MODE_10B_MASK;
		if (CFG_IN.mode == MODE_7B) begin
			match7 = |slot_eq;
		end else begin
			match7 = ~|((shift_reg[7:1] ^ MATCH_VALUE_IN[0][7:1]) & ~MATCH_VALUE_IN[1][7:1])
				| ~|((shift_reg[7:1] ^ MATCH_VALUE_IN[2][7:1]) & ~MATCH_VALUE_IN[3][7:1]);
		end
		match7 = match7 | (CFG_IN.general_call_en & shift_reg == GEN_CALL_ADDR);
		if (CFG_IN.mode == MODE_10B_MASK) begin
			hi_hit0  = ~|((shift_reg[7:1] ^ MATCH_VALUE_IN[1][7:1]) & ~MATCH_VALUE_IN[3][7:1]);
			hi_hit1  = 1'b0;
			// All fifteen stored bits take part, masked by pair 2/3
			match_lo = ~|(({hi_reg[7:1], shift_reg}
				^ {MATCH_VALUE_IN[1][7:1], MATCH_VALUE_IN[0]})
				& ~{MATCH_VALUE_IN[3][7:1], MATCH_VALUE_IN[2]});
		end else begin
			hi_hit0  = slot_eq[1];
			hi_hit1  = slot_eq[3];
			match_lo = (hit_reg[0] & shift_reg == MATCH_VALUE_IN[0])
				| (hit_reg[1] & shift_reg == MATCH_VALUE_IN[2]);
		end
		ack_bit  = nack_reg | (final_reg ? CFG_IN.final_ack_value : CFG_IN.ack_response_value);
		ev_addr  = CE_IN & fall_p & ~stop_p & ~start_p & bit_reg == BIT_BYTE_END;
		ev_data  = ev_addr & st_reg == ST_DATA;
		ev_ack   = ev_addr & st_reg == ST_ACK ? 1'b0 : CE_IN & fall_p & ~stop_p & ~start_p
			& st_reg == ST_ACK & bit_reg == BIT_ACK_END;
		ev_stall = CE_IN & fall_p & ~stop_p & ~start_p & st_reg == ST_DATA
			& bit_reg == BIT_RX_STALL & STAT_OUT.rx_full & ~CFG_IN.clk_stretch_dis;
		autoload = ev_data & first_reg & CFG_IN.count_autoload_en;
	end

	always_comb begin
		st_next     = st_reg;
		ack_to_next = ack_to_reg;
		bit_next    = bit_reg;
		shift_next  = shift_reg;
		hi_next     = hi_reg;
		hit_next    = hit_reg;
		first_next  = first_reg;
		nack_next   = nack_reg;
		final_next  = final_reg;
		pend_next   = pend_reg;
		stall_next  = stall_reg;
		cnt_next    = BYTE_COUNTER_OUT;
		rx_next     = RX_DATA_OUT;
		adb_next    = ADDR_BUF0_OUT;
		stat_next   = STAT_OUT;
		fl_set      = '0;
		go_ack      = 1'b0;
		hold        = 1'b0;
		// Software counter writes lose to a hardware update in the same cycle
		if (CNT_WR_IN) cnt_next = CNT_WDATA_IN;
		if (ERR_CLR_IN) stat_next.rx_overflow = 1'b0;
		if (STRETCH_CLR_IN) stat_next.stretch_flag = 1'b0;
		if (RX_READ_IN) begin
			stat_next.rx_full = 1'b0;
			if (stall_reg) begin
				stall_next             = 1'b0;
				stat_next.stretch_flag = 1'b0;
			end
		end
		if (stop_p) begin
			fl_set.stop_seen_flag   = 1'b1;
			st_next                 = ST_IDLE;
			stat_next.client_active = 1'b0;
		end else if (start_p) begin
			fl_set.start_seen_flag   = 1'b1;
			fl_set.combined_irq_flag = CFG_IN.start_irq_en;
			st_next                  = ST_ADDR;
			bit_next                 = BIT_ZERO;
		end else if (rise_p && st_reg != ST_IDLE) begin
			shift_next = {shift_reg[6:0], sda_s};
			bit_next   = bit_reg + BIT_ONE;
		end else if (fall_p && bit_reg == BIT_BYTE_END && st_reg != ST_ACK) begin
			unique case (st_reg)
				ST_ADDR: begin
					if (seven && match7) begin
						stat_next.client_active = 1'b1;
						stat_next.data_not_addr = 1'b0;
						stat_next.read_req      = shift_reg[0];
						if (CFG_IN.addr_buffer_disable) begin
							rx_next           = shift_reg;
							stat_next.rx_full = 1'b1;
						end else begin
							adb_next = shift_reg;
						end
						fl_set.address_match_flag = 1'b1;
						ack_to_next = shift_reg[0] ? ST_IDLE : ST_DATA;
						go_ack      = 1'b1;
						hold        = CFG_IN.address_hold_irq_en;
					end else if (ten && (hi_hit0 || hi_hit1)) begin
						stat_next.data_not_addr = 1'b0;
						stat_next.read_req      = shift_reg[0];
						hi_next     = shift_reg;
						hit_next    = {hi_hit1, hi_hit0};
						ack_to_next = ST_ADDR_LO;
						go_ack      = 1'b1;
						hold        = CFG_IN.address_hold_irq_en;
					end else begin
						st_next                 = ST_IDLE;
						stat_next.client_active = 1'b0;
					end
				end
				ST_ADDR_LO: begin
					if (match_lo) begin
						stat_next.client_active   = 1'b1;
						adb_next                  = shift_reg;
						fl_set.address_match_flag = 1'b1;
						ack_to_next = ST_DATA;
						go_ack      = 1'b1;
						hold        = CFG_IN.address_hold_irq_en;
					end else begin
						st_next = ST_IDLE;
					end
				end
				ST_DATA: begin
					stat_next.data_not_addr = 1'b1;
					fl_set.write_byte_flag  = 1'b1;
					if (STAT_OUT.rx_full) begin
						stat_next.rx_overflow = 1'b1;
					end else begin
						rx_next            = shift_reg;
						stat_next.rx_full  = 1'b1;
						fl_set.rx_irq_flag = 1'b1;
					end
					final_next = BYTE_COUNTER_OUT == BYTE_RST;
					pend_next  = 1'b0;
					if (autoload) begin
						cnt_next = shift_reg;
					end else if (BYTE_COUNTER_OUT != BYTE_RST) begin
						cnt_next  = BYTE_COUNTER_OUT - CNT_ONE;
						pend_next = BYTE_COUNTER_OUT == CNT_ONE;
					end
					first_next  = 1'b0;
					ack_to_next = ST_DATA;
					go_ack      = 1'b1;
					hold        = CFG_IN.write_hold_irq_en;
				end
				default: st_next = ST_IDLE;
			endcase
		end else if (fall_p && bit_reg == BIT_RX_STALL && ev_stall) begin
			stall_next             = 1'b1;
			stat_next.stretch_flag = 1'b1;
		end else if (fall_p && st_reg == ST_ACK && bit_reg == BIT_ACK_END) begin
			bit_next = BIT_ZERO;
			if (ack_bit) begin
				fl_set.nack_seen_flag   = 1'b1;
				st_next                 = ST_IDLE;
				stat_next.client_active = 1'b0;
			end else begin
				fl_set.count_zero_flag = pend_reg;
				pend_next = 1'b0;
				st_next   = ack_to_reg;
				hold      = CFG_IN.ack_time_hold_irq_en;
				if (ack_to_reg == ST_IDLE) stat_next.client_active = 1'b0;
			end
		end
		if (go_ack) begin
			st_next = ST_ACK;
			if (st_reg != ST_DATA) begin
				final_next = 1'b0;
				first_next = 1'b1;
			end
			// Any uncleared overflow turns the answer into NACK
			nack_next = stat_next.rx_overflow;
		end
		if (hold) begin
			stat_next.stretch_flag   = 1'b1;
			fl_set.combined_irq_flag = 1'b1;
		end
		flags_next = (FLAGS_OUT & ~FLAG_CLR_IN) | fl_set;
		if (RX_READ_IN && !fl_set.rx_irq_flag) flags_next.rx_irq_flag = 1'b0;
		scl_oe_next = stat_next.stretch_flag;
		// Ack drive starts one clock after entering, well inside SCL low
		sda_oe_next = st_reg == ST_ACK && st_next == ST_ACK && !ack_bit;
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			st_reg           <= ST_IDLE;
			ack_to_reg       <= ST_IDLE;
			bit_reg          <= BIT_ZERO;
			shift_reg        <= BYTE_RST;
			hi_reg           <= BYTE_RST;
			hit_reg          <= 2'h0;
			first_reg        <= 1'b0;
			nack_reg         <= 1'b0;
			final_reg        <= 1'b0;
			pend_reg         <= 1'b0;
			stall_reg        <= 1'b0;
			BYTE_COUNTER_OUT <= BYTE_RST;
			RX_DATA_OUT      <= BYTE_RST;
			ADDR_BUF0_OUT    <= BYTE_RST;
			STAT_OUT         <= '0;
			FLAGS_OUT        <= '0;
			SCL_OE_OUT       <= 1'b0;
			SDA_OE_OUT       <= 1'b0;
		end else if (CE_IN) begin
			st_reg           <= st_next;
			ack_to_reg       <= ack_to_next;
			bit_reg          <= bit_next;
			shift_reg        <= shift_next;
			hi_reg           <= hi_next;
			hit_reg          <= hit_next;
			first_reg        <= first_next;
			nack_reg         <= nack_next;
			final_reg        <= final_next;
			pend_reg         <= pend_next;
			stall_reg        <= stall_next;
			BYTE_COUNTER_OUT <= cnt_next;
			RX_DATA_OUT      <= rx_next;
			ADDR_BUF0_OUT    <= adb_next;
			STAT_OUT         <= stat_next;
			FLAGS_OUT        <= flags_next;
			SCL_OE_OUT       <= scl_oe_next;
			SDA_OE_OUT       <= sda_oe_next;
		end
	end

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	property p_addr_hold;
		ev_addr && st_reg == ST_ADDR && seven && match7 && CFG_IN.address_hold_irq_en
			|=> STAT_OUT.stretch_flag && SCL_OE_OUT;
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("No stretch after address");

	property p_write_hold;
		ev_data && CFG_IN.write_hold_irq_en |=> STAT_OUT.stretch_flag && SCL_OE_OUT;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("No stretch after data");

	property p_ack_hold;
		ev_ack && !ack_bit && CFG_IN.ack_time_hold_irq_en |=> STAT_OUT.stretch_flag;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("No stretch after ack");

	property p_cnt_floor;
		CE_IN && BYTE_COUNTER_OUT == BYTE_RST && !CNT_WR_IN && !autoload
			|=> BYTE_COUNTER_OUT == BYTE_RST;
	endproperty
	a_cnt_floor: assert property (p_cnt_floor) else $error("Counter wrapped below zero");

	property p_cnt_zero;
		ev_ack && !ack_bit && pend_reg |=> FLAGS_OUT.count_zero_flag;
	endproperty
	a_cnt_zero: assert property (p_cnt_zero) else $error("Count-zero flag missing");

	property p_no_match;
		ev_addr && st_reg == ST_ADDR && seven && !match7
			|=> st_reg == ST_IDLE && !STAT_OUT.client_active ##1 !SDA_OE_OUT;
	endproperty
	a_no_match: assert property (p_no_match) else $error("Response to foreign address");

	property p_rw_copy;
		ev_addr && st_reg == ST_ADDR && seven && match7
			|=> STAT_OUT.read_req == $past(shift_reg[0]) && STAT_OUT.client_active;
	endproperty
	a_rw_copy: assert property (p_rw_copy) else $error("Read request not copied");

	property p_start;
		CE_IN && start_p && !stop_p |=> FLAGS_OUT.start_seen_flag && st_reg == ST_ADDR;
	endproperty
	a_start: assert property (p_start) else $error("Start not flagged");

	property p_err_nack;
		ev_addr && st_reg == ST_ADDR && seven && match7 && STAT_OUT.rx_overflow && !ERR_CLR_IN
			|=> nack_reg ##1 !SDA_OE_OUT;
	endproperty
	a_err_nack: assert property (p_err_nack) else $error("Error did not force NACK");

	property p_rx_load;
		ev_data && !STAT_OUT.rx_full |=> STAT_OUT.rx_full && FLAGS_OUT.write_byte_flag
			&& RX_DATA_OUT == $past(shift_reg);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("Receive buffer not loaded");

	property p_stop;
		CE_IN && stop_p |=> st_reg == ST_IDLE && FLAGS_OUT.stop_seen_flag;
	endproperty
	a_stop: assert property (p_stop) else $error("Stop not handled");

	c_match: cover property (ev_addr && st_reg == ST_ADDR && match7);
	c_byte: cover property (ev_data && !STAT_OUT.rx_full);
	c_stall: cover property (ev_stall);
	c_zero: cover property (ev_ack && pend_reg);

endmodule

/* File: iac_pkg.sv */
// Shared constants and carriers for the I2C client address and receive block.
// Assumes a single system clock domain; bus pins are synchronised in iac_sync.
package iac_pkg;

	// Client addressing modes
	localparam logic [2:0] MODE_7B       = 3'h0;
	localparam logic [2:0] MODE_7B_MASK  = 3'h1;
	localparam logic [2:0] MODE_10B      = 3'h2;
	localparam logic [2:0] MODE_10B_MASK = 3'h3;
	localparam logic [2:0] MODE_MH_MASK  = 3'h7;

	// SCL edge counts within a byte
	localparam logic [3:0] BIT_ZERO      = 4'h0;
	localparam logic [3:0] BIT_RX_STALL  = 4'h7;
	localparam logic [3:0] BIT_BYTE_END  = 4'h8;
	localparam logic [3:0] BIT_ACK_END   = 4'h9;
	localparam logic [3:0] BIT_ONE       = 4'h1;

	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [7:0] BYTE_RST      = 8'h00;
	localparam logic [7:0] CNT_ONE       = 8'h01;
	localparam logic [1:0] SYNC_RST      = 2'h3;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_ADDR    = 5'b00010,
		ST_ADDR_LO = 5'b00100,
		ST_ACK     = 5'b01000,
		ST_DATA    = 5'b10000
	} iac_state_e;

	typedef struct packed {
		logic [2:0] mode;
		logic       general_call_en;
		logic       address_hold_irq_en;
		logic       write_hold_irq_en;
		logic       ack_time_hold_irq_en;
		logic       start_irq_en;
		logic       count_autoload_en;
		logic       addr_buffer_disable;
		logic       clk_stretch_dis;
		logic       ack_response_value;
		logic       final_ack_value;
	} iac_cfg_s;

	typedef struct packed {
		logic start_seen_flag;
		logic address_match_flag;
		logic write_byte_flag;
		logic rx_irq_flag;
		logic count_zero_flag;
		logic nack_seen_flag;
		logic stop_seen_flag;
		logic combined_irq_flag;
	} iac_flags_s;

	typedef struct packed {
		logic client_active;
		logic read_req;
		logic data_not_addr;
		logic stretch_flag;
		logic rx_full;
		logic rx_overflow;
	} iac_stat_s;

endpackage

/* File: iac_sync.sv */
// Two-flop synchronisers for SCL and SDA plus edge, start and stop detection.
// Assumes SCL/SDA are asynchronous to CLK and much slower than it.
`timescale 1ns/1ps
module iac_sync (
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic ce_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      rise_out,
	output logic      fall_out,
	output logic      start_out,
	output logic      stop_out
);
	import iac_pkg::*;

	// Index 0 is the first synchroniser stage and feeds only index 1
	logic [1:0] scl_reg, scl_next, sda_reg, sda_next;
	logic       scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
	logic       sda_o_next, rise_next, fall_next, start_next, stop_next;

	always_comb begin
		scl_next   = {scl_reg[0], scl_in};
		sda_next   = {sda_reg[0], sda_in};
		scl_d_next = scl_reg[1];
		sda_d_next = sda_reg[1];
		sda_o_next = sda_reg[1];
		rise_next  = scl_reg[1] & ~scl_d_reg;
		fall_next  = ~scl_reg[1] & scl_d_reg;
		// Start and stop only count while SCL stays high
		start_next = scl_reg[1] & scl_d_reg & ~sda_reg[1] & sda_d_reg;
		stop_next  = scl_reg[1] & scl_d_reg & sda_reg[1] & ~sda_d_reg;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scl_reg   <= SYNC_RST;
			sda_reg   <= SYNC_RST;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sda_out   <= 1'b1;
			rise_out  <= 1'b0;
			fall_out  <= 1'b0;
			start_out <= 1'b0;
			stop_out  <= 1'b0;
		end else if (ce_in) begin
			scl_reg   <= scl_next;
			sda_reg   <= sda_next;
			scl_d_reg <= scl_d_next;
			sda_d_reg <= sda_d_next;
			sda_out   <= sda_o_next;
			rise_out  <= rise_next;
			fall_out  <= fall_next;
			start_out <= start_next;
			stop_out  <= stop_next;
		end
	end

endmodule

/* File: iac_host_model.sv */
// I2C host model: pulls SCL and SDA low through open-drain outputs.
// Assumes pull-ups on both wires, a 125 ns SCL period and a stretching client.
`timescale 1ns/1ps
module iac_host_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_low_out,
	output logic      sda_low_out
);
	localparam realtime QTR = 31.25;

	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end

	// Bounded wait so a hold that is never released cannot hang the host
	task automatic scl_high();
		int n;
		n = 0;
		scl_low_out = 1'b0;
		while (scl_in !== 1'b1 && n < 200) begin
			#QTR;
			n++;
		end
		#(2 * QTR);
	endtask

	task automatic start();
		sda_low_out = 1'b0;
		#QTR;
		scl_high();
		sda_low_out = 1'b1;
		#(2 * QTR);
		scl_low_out = 1'b1;
		#QTR;
	endtask

	// Data moves only while SCL is low, a quarter period after the fall
	task automatic put_bit(input logic b);
		sda_low_out = ~b;
		#QTR;
		scl_high();
		scl_low_out = 1'b1;
		#QTR;
	endtask

	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		sda_low_out = 1'b0;
		#QTR;
		scl_high();
		ack = sda_in;
		scl_low_out = 1'b1;
		#QTR;
	endtask

	task automatic stop();
		sda_low_out = 1'b1;
		#QTR;
		scl_high();
		sda_low_out = 1'b0;
		#(2 * QTR);
	endtask
endmodule

/* File: iac_client_tb.sv */
// Self-checking bench for iac_client; the bench plays the software side.
// Assumes iac_host_model on pulled-up wires and a 125 MHz system clock.
`timescale 1ns/1ps
module iac_client_tb;
	import iac_pkg::*;
	logic            clk, rstn, ce, stretch_clr, rx_read, err_clr, cnt_wr;
	logic            scl_oe, sda_oe, h_scl, h_sda, scl_w, sda_w;
	logic [7:0]      cnt_wdata, rxd, adb, cnt;
	logic [3:0][7:0] mv;
	iac_cfg_s        cfg;
	iac_flags_s      fclr, fl;
	iac_stat_s       st;
	int              err_total, comparisons;

	assign scl_w = ~(h_scl | scl_oe);
	assign sda_w = ~(h_sda | sda_oe);

	iac_client DUT (
		.CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(ce), .SCL_IN(scl_w), .SDA_IN(sda_w),
		.SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
		.CFG_IN(cfg), .MATCH_VALUE_IN(mv), .STRETCH_CLR_IN(stretch_clr),
		.RX_READ_IN(rx_read), .ERR_CLR_IN(err_clr), .FLAG_CLR_IN(fclr),
		.CNT_WR_IN(cnt_wr), .CNT_WDATA_IN(cnt_wdata), .STAT_OUT(st), .FLAGS_OUT(fl),
		.RX_DATA_OUT(rxd), .ADDR_BUF0_OUT(adb), .BYTE_COUNTER_OUT(cnt)
	);

	iac_host_model hm (
		.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(h_scl), .sda_low_out(h_sda)
	);

	always #4 clk = ~clk;

	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	// 0 clears the hold, 1 reads the receive buffer, else services everything
	task automatic pulse(input int k);
		@(posedge clk);
		#1;
		stretch_clr = (k != 1);
		rx_read = (k != 0);
		err_clr = (k > 1);
		fclr = (k > 1) ? '1 : '0;
		@(posedge clk);
		#1;
		{stretch_clr, rx_read, err_clr} = 3'h0;
		fclr = '0;
	endtask

	task automatic setcnt(input logic [7:0] v);
		@(posedge clk);
		#1;
		cnt_wr = 1'b1;
		cnt_wdata = v;
		@(posedge clk);
		#1;
		cnt_wr = 1'b0;
	endtask

	task automatic prep(input logic [2:0] md);
		pulse(2);
		cfg = '0;
		cfg.mode = md;
		cfg.final_ack_value = 1'b1;
	endtask

	task automatic tx(input logic [7:0] d, input logic a, input string m);
		logic got;
		hm.put_byte(d, got);
		settle();
		chk({7'h0, got}, {7'h0, a}, m);
	endtask

	// Waits for the hold, checks SCL is pulled, picks the ack value, releases
	task automatic hold_rel(input int k, input logic nack);
		int n;
		n = 0;
		while (st.stretch_flag !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		settle();
		chk({7'h0, scl_oe}, 8'h01, "hold");
		cfg.ack_response_value = nack;
		pulse(k);
	endtask

	task automatic try(input logic [2:0] md, input logic gc, input logic [7:0] b0,
			input logic [7:0] b1, input logic a0, input logic a1);
		logic ten;
		ten = (md == MODE_10B || md == MODE_10B_MASK);
		prep(md);
		cfg.general_call_en = gc;
		hm.start();
		tx(b0, a0, "adr0");
		if (ten && !a0) begin
			tx(b1, a1, "adr1");
		end
		hm.stop();
		settle();
		chk({7'h0, fl.address_match_flag}, {7'h0, ~(ten ? a0 | a1 : a0)}, "amf");
	endtask

	task automatic t_rx();
		prep(MODE_7B);
		cfg.start_irq_en = 1'b1;
		setcnt(8'h02);
		hm.start();
		settle();
		chk({6'h0, fl.start_seen_flag, fl.combined_irq_flag}, 8'h03, "start");
		tx(8'h55, 1'b0, "rd");
		chk({7'h0, st.read_req}, 8'h01, "rd");
		hm.start();
		tx(8'h66, 1'b0, "wr");
		chk(adb, 8'h66, "adb");
		chk({5'h0, st.client_active, st.read_req, st.data_not_addr}, 8'h04, "act");
		tx(8'hA5, 1'b0, "d1");
		chk(rxd, 8'hA5, "rxd");
		chk(cnt, 8'h01, "cnt");
		chk({5'h0, fl.write_byte_flag, st.rx_full, st.data_not_addr}, 8'h07, "wb");
		chk({7'h0, fl.rx_irq_flag}, 8'h01, "rxif");
		pulse(1);
		tx(8'h3C, 1'b0, "d2");
		chk({fl.count_zero_flag, cnt[6:0]}, 8'h80, "cz");
		pulse(1);
		tx(8'h11, 1'b1, "d3");
		chk({cnt[6:0], fl.nack_seen_flag}, 8'h01, "nk");
		hm.stop();
		settle();
		chk({6'h0, fl.stop_seen_flag, st.client_active}, 8'h02, "stop");
	endtask

	task automatic t_addr();
		try(MODE_7B, 1'b0, 8'h20, 8'h00, 1'b0, 1'b1);
		try(MODE_7B, 1'b0, 8'h7F, 8'h00, 1'b0, 1'b1);
		try(MODE_7B, 1'b0, 8'h30, 8'h00, 1'b1, 1'b1);
		try(MODE_7B, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
		try(MODE_7B, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
		try(MODE_7B_MASK, 1'b0, 8'h74, 8'h00, 1'b0, 1'b1);
		try(MODE_7B_MASK, 1'b0, 8'h88, 8'h00, 1'b1, 1'b1);
		try(MODE_MH_MASK, 1'b0, 8'h74, 8'h00, 1'b0, 1'b1);
		try(MODE_10B, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1);
		try(MODE_10B, 1'b0, 8'h54, 8'h20, 1'b0, 1'b0);
		try(MODE_10B, 1'b0, 8'h7E, 8'h66, 1'b0, 1'b0);
		try(MODE_10B, 1'b0, 8'h54, 8'h66, 1'b0, 1'b1);
		try(MODE_10B, 1'b0, 8'h74, 8'h20, 1'b1, 1'b1);
		try(MODE_10B_MASK, 1'b0, 8'h02, 8'h46, 1'b0, 1'b0);
		try(MODE_10B_MASK, 1'b0, 8'h02, 8'h21, 1'b0, 1'b1);
		try(3'h4, 1'b0, 8'h20, 8'h00, 1'b1, 1'b1);
	endtask

	task automatic t_hold();
		prep(MODE_7B);
		cfg.general_call_en = 1'b1;
		cfg.address_hold_irq_en = 1'b1;
		cfg.write_hold_irq_en = 1'b1;
		cfg.ack_time_hold_irq_en = 1'b1;
		setcnt(8'h05);
		hm.start();
		fork
			tx(8'h00, 1'b0, "gc");
			hold_rel(0, 1'b0);
		join
		hold_rel(0, 1'b0);
		chk({7'h0, fl.combined_irq_flag}, 8'h01, "cirq");
		fork
			tx(8'h5A, 1'b0, "w1");
			hold_rel(0, 1'b0);
		join
		hold_rel(0, 1'b0);
		pulse(1);
		cfg.ack_time_hold_irq_en = 1'b0;
		fork
			tx(8'h5B, 1'b1, "w2");
			hold_rel(0, 1'b1);
		join
		hm.stop();
	endtask

	task automatic t_stall();
		prep(MODE_7B);
		setcnt(8'h09);
		hm.start();
		tx(8'h20, 1'b0, "a");
		tx(8'h01, 1'b0, "d1");
		fork
			tx(8'h02, 1'b0, "d2");
			hold_rel(1, 1'b0);
		join
		chk(rxd, 8'h02, "rxd");
		cfg.clk_stretch_dis = 1'b1;
		tx(8'h03, 1'b1, "ovf");
		chk({rxd[6:0], st.rx_overflow}, 8'h05, "ovf");
		hm.stop();
		hm.start();
		tx(8'h20, 1'b1, "err");
		hm.stop();
		pulse(2);
		chk({7'h0, st.rx_overflow}, 8'h00, "eclr");
	endtask

	task automatic t_auto();
		prep(MODE_7B);
		cfg.count_autoload_en = 1'b1;
		cfg.final_ack_value = 1'b0;
		cfg.addr_buffer_disable = 1'b1;
		setcnt(8'h00);
		// A counter write while frozen is lost, so zero must remain
		ce = 1'b0;
		setcnt(8'h07);
		ce = 1'b1;
		chk(cnt, 8'h00, "ce");
		hm.start();
		tx(8'h20, 1'b0, "a");
		chk({st.rx_full, rxd[6:0]}, 8'hA0, "abd");
		pulse(1);
		tx(8'h03, 1'b0, "ld");
		chk(cnt, 8'h03, "ld");
		pulse(1);
		tx(8'h44, 1'b0, "d");
		chk(cnt, 8'h02, "dec");
		hm.stop();
	endtask

	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		{stretch_clr, rx_read, err_clr, cnt_wr} = 4'h0;
		ce = 1'b1;
		cnt_wdata = 8'h00;
		cfg = '0;
		fclr = '0;
		mv = {8'h7E, 8'h66, 8'h54, 8'h20};
		err_total = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		settle();
		chk({scl_oe, sda_oe, cnt[5:0]}, 8'h00, "rst");
		t_rx();
		t_addr();
		t_hold();
		t_stall();
		t_auto();
		report_and_stop();
	end
endmodule
